// file: hdl/mfd_pkg.sv
// constants and types shared by the modem format and deviation configuration block
package mfd_pkg;

  // ----------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_MODEM_CONFIG = 8'h0d;
  localparam logic [7:0] IDX_TX_DEVIATION = 8'h0e;
  localparam logic [7:0] IDX_REF_DIV = 8'h20;
  localparam logic [7:0] IDX_STATUS = 8'h21;
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 9;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int MODEM_FMT_LSB = 0;
  localparam int MODEM_SCR_BIT = 2;
  localparam int MODEM_ADC_LSB = 4;
  localparam int DEV_M_LSB = 0;
  localparam int DEV_X_LSB = 4;
  localparam int DEV_SHAPE_BIT = 7;
  localparam int REF_DIV_LSB = 0;
  localparam int STAT_DEV_LSB = 0;
  localparam int STAT_OOK_BIT = 12;
  localparam int STAT_ADC_BAD_BIT = 13;
  localparam int STAT_REF_BAD_BIT = 14;
  localparam int STAT_UART_BIT = 15;
  localparam int STAT_PRBS_LSB = 16;

  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [2:0] RST_ADC_DIV = 3'h3;
  localparam logic RST_SCR_EN = 1'b0;
  localparam logic [1:0] RST_FMT = 2'h0;
  localparam logic RST_SHAPING = 1'b1;
  localparam logic [2:0] RST_DEV_X = 3'h6;
  localparam logic [3:0] RST_DEV_M = 4'h8;
  localparam logic [2:0] RST_REF_DIV = 3'h2;

  // ----------------------------------------
  // data format codes
  // ----------------------------------------
  localparam logic [1:0] FMT_NRZ = 2'h0;
  localparam logic [1:0] FMT_MANCHESTER = 2'h1;
  localparam logic [1:0] FMT_UART_LOW = 2'h2;
  localparam logic [1:0] FMT_UART_HIGH = 2'h3;

  // ----------------------------------------
  // scrambler generator
  // ----------------------------------------
  localparam int PRBS_LEN = 9;
  localparam int PRBS_TAP = 5;
  localparam logic [8:0] PRBS_SEED = 9'h1ff;

  // ----------------------------------------
  // bus encodings
  // ----------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic {
    MFD_BUS_IDLE,
    MFD_BUS_WRITE
  } mfd_bus_phase_t;

endpackage : mfd_pkg

// file: hdl/mfd_prbs9.sv
// nine-stage pseudo-random sequence generator used by the scrambler
`timescale 1ns/10ps
module mfd_prbs9 (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic restart_i,
  input wire logic step_i,
  output logic bit_o,
  output logic [mfd_pkg::PRBS_LEN-1:0] state_o
);
  import mfd_pkg::*;

  typedef struct packed {
    logic [PRBS_LEN-1:0] lfsr;
  } mfd_prbs_state_t;

  mfd_prbs_state_t s_reg;
  mfd_prbs_state_t s_next;

  // ----------------------------------------
  // generator
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    if (restart_i) begin
      s_next.lfsr = PRBS_SEED;
    end else if (step_i) begin
      // feedback from stages nine and five, x^9 + x^5 + 1
      s_next.lfsr = {s_reg.lfsr[PRBS_LEN-2:0],
                     s_reg.lfsr[PRBS_LEN-1] ^ s_reg.lfsr[PRBS_TAP-1]};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_reg.lfsr <= PRBS_SEED;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bit_o = s_reg.lfsr[PRBS_LEN-1];
  assign state_o = s_reg.lfsr;

endmodule : mfd_prbs9

// file: hdl/mfd_top.sv
// modem format, scrambler and transmit deviation configuration with an AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/10ps
module mfd_top (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic band_upper_i,
  input wire logic data_clk_i,
  input wire logic tx_bit_i,
  input wire logic tx_valid_i,
  input wire logic rx_bit_i,
  input wire logic rx_valid_i,
  output logic tx_bit_o,
  output logic tx_valid_o,
  output logic rx_bit_o,
  output logic rx_valid_o,
  output logic data_clock_pin_o,
  output logic fmt_nrz_o,
  output logic fmt_manchester_o,
  output logic fmt_uart_o,
  output logic scrambler_enable_o,
  output logic shaping_enable_o,
  output logic ook_mode_o,
  output logic [11:0] dev_step_o,
  output logic adc_clk_o,
  output logic adc_tick_o,
  output logic ref_tick_o
);
  import mfd_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    mfd_bus_phase_t phase;
    logic [7:0] wr_index;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [2:0] adc_div;
    logic scr_en;
    logic [1:0] fmt;
    logic shaping;
    logic [2:0] dev_x;
    logic [3:0] dev_m;
    logic [2:0] ref_div;
    logic [2:0] adc_cnt;
    logic adc_clk;
    logic adc_tick;
    logic [2:0] ref_cnt;
    logic ref_tick;
    logic tx_bit;
    logic tx_valid;
    logic rx_bit;
    logic rx_valid;
    logic data_clock_pin;
    logic f_nrz;
    logic f_man;
    logic f_uart;
    logic ook;
    logic [11:0] dev_step;
  } mfd_top_state_t;

  mfd_top_state_t s_reg;
  mfd_top_state_t s_next;

  logic tx_prbs;
  logic rx_prbs;
  logic [PRBS_LEN-1:0] tx_prbs_state;
  logic take;
  logic word_ok;
  logic [7:0] idx;

  // ----------------------------------------
  // scrambler generators
  // ----------------------------------------
  // each direction owns its generator so tx and rx run independently
  mfd_prbs9 u_tx_prbs (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .restart_i(~s_reg.scr_en),
    .step_i(tx_valid_i & s_reg.scr_en),
    .bit_o(tx_prbs),
    .state_o(tx_prbs_state)
  );

  mfd_prbs9 u_rx_prbs (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .restart_i(~s_reg.scr_en),
    .step_i(rx_valid_i & s_reg.scr_en),
    .bit_o(rx_prbs),
    .state_o()
  );

  // ----------------------------------------
  // read multiplexer
  // ----------------------------------------
  function automatic logic [31:0] mfd_read(input mfd_top_state_t st,
                                           input logic [7:0] ix,
                                           input logic [PRBS_LEN-1:0] ps);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (ix)
      IDX_MODEM_CONFIG: begin
        // reserved bits 7 and 3 stay zero
        v[MODEM_ADC_LSB +: 3] = st.adc_div;
        v[MODEM_SCR_BIT] = st.scr_en;
        v[MODEM_FMT_LSB +: 2] = st.fmt;
      end
      IDX_TX_DEVIATION: begin
        v[DEV_SHAPE_BIT] = st.shaping;
        v[DEV_X_LSB +: 3] = st.dev_x;
        v[DEV_M_LSB +: 4] = st.dev_m;
      end
      IDX_REF_DIV: begin
        v[REF_DIV_LSB +: 3] = st.ref_div;
      end
      IDX_STATUS: begin
        v[STAT_DEV_LSB +: 12] = st.dev_step;
        v[STAT_OOK_BIT] = st.ook;
        v[STAT_ADC_BAD_BIT] = (st.adc_div == 3'h0);
        v[STAT_REF_BAD_BIT] = (st.ref_div == 3'h0);
        v[STAT_UART_BIT] = st.f_uart;
        v[STAT_PRBS_LSB +: PRBS_LEN] = ps;
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction : mfd_read

  assign take = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ || htrans_i == 2'h3);
  assign word_ok = (hsize_i == HSIZE_WORD) & (haddr_i[31:ADDR_IDX_MSB+1] == 22'h00_0000)
                   & (haddr_i[1:0] == 2'h0);
  assign idx = haddr_i[ADDR_IDX_MSB:ADDR_IDX_LSB];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.hreadyout = 1'b1;
    s_next.hresp = HRESP_OKAY;
    s_next.adc_tick = 1'b0;
    s_next.ref_tick = 1'b0;

    // data phase of a write lands here
    if (s_reg.phase == MFD_BUS_WRITE) begin
      unique case (s_reg.wr_index)
        IDX_MODEM_CONFIG: begin
          s_next.adc_div = hwdata_i[MODEM_ADC_LSB +: 3];
          s_next.scr_en = hwdata_i[MODEM_SCR_BIT];
          s_next.fmt = hwdata_i[MODEM_FMT_LSB +: 2];
        end
        IDX_TX_DEVIATION: begin
          s_next.shaping = hwdata_i[DEV_SHAPE_BIT];
          s_next.dev_x = hwdata_i[DEV_X_LSB +: 3];
          s_next.dev_m = hwdata_i[DEV_M_LSB +: 4];
        end
        IDX_REF_DIV: begin
          s_next.ref_div = hwdata_i[REF_DIV_LSB +: 3];
        end
        default: begin
          s_next.ref_div = s_reg.ref_div;
        end
      endcase
    end

    // address phase; unmapped or narrow accesses write nothing and read zero
    s_next.phase = MFD_BUS_IDLE;
    if (take) begin
      if (hwrite_i) begin
        s_next.phase = word_ok ? MFD_BUS_WRITE : MFD_BUS_IDLE;
        s_next.wr_index = idx;
      end
    end

    // adc clock: half period of divisor+1 crystal cycles, code 0 holds it
    if (s_reg.adc_div == 3'h0) begin
      s_next.adc_cnt = 3'h0;
    end else if (s_reg.adc_cnt >= s_reg.adc_div) begin
      s_next.adc_cnt = 3'h0;
      s_next.adc_clk = ~s_reg.adc_clk;
      s_next.adc_tick = ~s_reg.adc_clk;
    end else begin
      s_next.adc_cnt = s_reg.adc_cnt + 3'h1;
    end

    // reference tick every ref_div+1 crystal cycles, code 0 stops it
    if (s_reg.ref_div == 3'h0) begin
      s_next.ref_cnt = 3'h0;
    end else if (s_reg.ref_cnt >= s_reg.ref_div) begin
      s_next.ref_cnt = 3'h0;
      s_next.ref_tick = 1'b1;
    end else begin
      s_next.ref_cnt = s_reg.ref_cnt + 3'h1;
    end

    // scrambling of both directions; bypass passes bits untouched
    s_next.tx_bit = tx_bit_i ^ (s_reg.scr_en & tx_prbs);
    s_next.tx_valid = tx_valid_i;
    s_next.rx_bit = rx_bit_i ^ (s_reg.scr_en & rx_prbs);
    s_next.rx_valid = rx_valid_i;

    // line format decode from the new setting
    s_next.f_nrz = (s_next.fmt == FMT_NRZ);
    s_next.f_man = (s_next.fmt == FMT_MANCHESTER);
    s_next.f_uart = (s_next.fmt == FMT_UART_LOW) | (s_next.fmt == FMT_UART_HIGH);
    if (s_next.f_uart) begin
      s_next.data_clock_pin = s_next.fmt[0];
    end else begin
      s_next.data_clock_pin = data_clk_i;
    end

    // zero mantissa switches the transmit deviation to on-off keying; the rx path ignores it
    s_next.ook = (s_next.dev_m == 4'h0);

    // deviation = fref * dev_step / 2^16; upper band shifts one more
    s_next.dev_step = {8'h00, s_next.dev_m} << ({1'b0, s_next.dev_x} + {3'h0, band_upper_i});

    if (take && !hwrite_i) begin
      s_next.hrdata = word_ok ? mfd_read(s_next, idx, tx_prbs_state) : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.phase <= MFD_BUS_IDLE;
      s_reg.hreadyout <= 1'b1;
      s_reg.hresp <= HRESP_OKAY;
      s_reg.adc_div <= RST_ADC_DIV;
      s_reg.scr_en <= RST_SCR_EN;
      s_reg.fmt <= RST_FMT;
      s_reg.shaping <= RST_SHAPING;
      s_reg.dev_x <= RST_DEV_X;
      s_reg.dev_m <= RST_DEV_M;
      s_reg.ref_div <= RST_REF_DIV;
      s_reg.f_nrz <= 1'b1;
      s_reg.dev_step <= 12'h200;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output is a field of the state register, so none has a combinational path
  assign hrdata_o = s_reg.hrdata;
  assign hreadyout_o = s_reg.hreadyout;
  assign hresp_o = s_reg.hresp;
  assign tx_bit_o = s_reg.tx_bit;
  assign tx_valid_o = s_reg.tx_valid;
  assign rx_bit_o = s_reg.rx_bit;
  assign rx_valid_o = s_reg.rx_valid;
  assign data_clock_pin_o = s_reg.data_clock_pin;
  assign fmt_nrz_o = s_reg.f_nrz;
  assign fmt_manchester_o = s_reg.f_man;
  assign fmt_uart_o = s_reg.f_uart;
  assign scrambler_enable_o = s_reg.scr_en;
  assign shaping_enable_o = s_reg.shaping;
  assign ook_mode_o = s_reg.ook;
  assign dev_step_o = s_reg.dev_step;
  assign adc_clk_o = s_reg.adc_clk;
  assign adc_tick_o = s_reg.adc_tick;
  assign ref_tick_o = s_reg.ref_tick;

endmodule : mfd_top

// file: verif/mfd_top_props.sv
// concurrent property checker for the modem format and deviation block
`timescale 1ns/10ps
module mfd_top_props (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic data_clk_i,
  input wire logic tx_bit_i,
  input wire logic tx_valid_i,
  input wire logic rx_valid_i,
  input wire logic tx_bit_o,
  input wire logic tx_valid_o,
  input wire logic rx_valid_o,
  input wire logic data_clock_pin_o,
  input wire logic fmt_nrz_o,
  input wire logic fmt_manchester_o,
  input wire logic fmt_uart_o,
  input wire logic scrambler_enable_o,
  input wire logic ook_mode_o,
  input wire logic [11:0] dev_step_o,
  input wire logic adc_clk_o,
  input wire logic adc_tick_o,
  input wire logic ref_tick_o
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  fmt_onehot_a: assert property ($onehot({fmt_nrz_o, fmt_manchester_o, fmt_uart_o}))
    else $error("format flags not one-hot");
  // format flag and pin load on the same edge, so the flag of this cycle qualifies the pin
  clk_forward_a: assert property (
    !$past(rst_i) && !fmt_uart_o |-> data_clock_pin_o == $past(data_clk_i))
    else $error("data clock not forwarded");
  ook_zero_a: assert property (ook_mode_o == (dev_step_o == 12'h000))
    else $error("ook flag disagrees with mantissa");
  tx_pass_a: assert property (
    !scrambler_enable_o && tx_valid_i |=> tx_valid_o && tx_bit_o == $past(tx_bit_i))
    else $error("tx bit altered with scrambler off");
  tx_idle_a: assert property (!tx_valid_i |=> !tx_valid_o)
    else $error("tx strobe without input");
  rx_strobe_a: assert property (rx_valid_i |=> rx_valid_o)
    else $error("rx strobe lost");
  adc_half_a: assert property ($rose(adc_clk_o) |=> adc_clk_o ##[1:15] !adc_clk_o)
    else $error("adc clock half period out of range");
  adc_space_a: assert property (adc_tick_o |=> !adc_tick_o [*3])
    else $error("adc ticks closer than four cycles");
  adc_edge_a: assert property ($rose(adc_clk_o) |-> ##[0:1] adc_tick_o)
    else $error("adc tick missing at rising clock");
  ref_space_a: assert property (ref_tick_o |=> !ref_tick_o)
    else $error("reference ticks closer than two cycles");
endmodule : mfd_top_props

bind mfd_top mfd_top_props u_mfd_top_props (.*);

// file: verif/mfd_top_bench.sv
// self-checking bench for the modem format and deviation block
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end
module mfd_top_bench;
  import mfd_pkg::*;
  logic clock_i = 0, rst_i = 1, hsel_i = 0, hwrite_i = 0, band_upper_i = 0, data_clk_i = 0;
  logic tx_bit_i = 0, tx_valid_i = 0, rx_bit_i = 0, rx_valid_i = 0;
  logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o, rd;
  logic [1:0] htrans_i = '0;
  logic [2:0] hsize_i = HSIZE_WORD;
  logic hreadyout_o, hresp_o, tx_bit_o, tx_valid_o, rx_bit_o, rx_valid_o, data_clock_pin_o;
  logic fmt_nrz_o, fmt_manchester_o, fmt_uart_o, scrambler_enable_o, shaping_enable_o;
  logic ook_mode_o, adc_clk_o, adc_tick_o, ref_tick_o;
  logic [11:0] dev_step_o;
  logic [8:0] lfsr;
  int err_total = 0;
  int checks = 0;
  int n;

  always #5 clock_i = ~clock_i;

  // hreadyout doubles as the bus hready since this is the only slave
  mfd_top u_mfd_top (.*, .hready_i(hreadyout_o));

  // ----------------------------------------
  // bus and measurement tasks
  // ----------------------------------------
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge clock_i);
    hsel_i <= 1'b1;
    htrans_i <= HTRANS_NONSEQ;
    hwrite_i <= wr;
    haddr_i <= {22'h00_0000, idx, 2'h0};
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    hsel_i <= 1'b0;
    #1;
  endtask : bus

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0000_0000);
    `CHK(rd, exp)
    `CHK(hresp_o, HRESP_OKAY)
  endtask : rdchk

  // the first gap after a write may be stale, so the third one is judged
  task automatic gap(input bit adc, input int exp);
    repeat (3) begin
      n = 0;
      do begin
        @(posedge clock_i);
        #1;
        n++;
      end while ((adc ? adc_tick_o : ref_tick_o) !== 1'b1 && n < 40);
    end
    `CHK(n, exp)
  endtask : gap

  task automatic tally_and_finish();
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    rdchk(IDX_MODEM_CONFIG, 32'h0000_0030);
    rdchk(IDX_TX_DEVIATION, 32'h0000_00e8);
    `CHK({fmt_nrz_o, shaping_enable_o, ook_mode_o, scrambler_enable_o}, 4'b1100)
    `CHK(dev_step_o, 12'h200)
    bus(IDX_MODEM_CONFIG, 1'b1, 32'h0000_00ff);
    rdchk(IDX_MODEM_CONFIG, 32'h0000_0077);
    bus(8'h10, 1'b1, 32'h0000_00ff);
    rdchk(8'h10, 32'h0000_0000);
    @(posedge clock_i);
    data_clk_i <= 1'b1;
    for (int f = 0; f < 4; f++) begin
      bus(IDX_MODEM_CONFIG, 1'b1, 32'h0000_0030 | f);
      `CHK({fmt_uart_o, fmt_manchester_o, fmt_nrz_o}, f > 1 ? 3'b100 : f ? 3'b010 : 3'b001)
      `CHK(data_clock_pin_o, (f != 2))
    end
    @(posedge clock_i);
    data_clk_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    `CHK(data_clock_pin_o, 1'b1)
    for (int c = 1; c < 8; c++) begin
      bus(IDX_MODEM_CONFIG, 1'b1, c << 4);
      gap(1, 2 * c + 2);
    end
    for (int c = 1; c < 8; c += 3) begin
      bus(IDX_REF_DIV, 1'b1, c);
      gap(0, c + 1);
    end
    bus(IDX_TX_DEVIATION, 1'b1, 32'h0000_0025);
    `CHK({shaping_enable_o, ook_mode_o, dev_step_o}, {2'b00, 12'h014})
    @(posedge clock_i);
    band_upper_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
    `CHK(dev_step_o, 12'h028)
    bus(IDX_TX_DEVIATION, 1'b1, 32'h0000_007f);
    `CHK(dev_step_o, 12'hf00)
    rdchk(IDX_TX_DEVIATION, 32'h0000_007f);
    bus(IDX_TX_DEVIATION, 1'b1, 32'h0000_00f0);
    `CHK({ook_mode_o, dev_step_o}, 13'h1000)
    rdchk(IDX_STATUS, 32'h01ff_1000);
    // zeros on tx expose the raw sequence, as in a bit error count
    bus(IDX_MODEM_CONFIG, 1'b1, 32'h0000_0034);
    lfsr = PRBS_SEED;
    for (int i = 0; i < 13; i++) begin
      @(posedge clock_i);
      tx_valid_i <= (i < 12);
      rx_valid_i <= (i < 12);
      rx_bit_i <= i[0];
      #1;
      if (i > 0) begin
        `CHK({tx_valid_o, rx_valid_o, tx_bit_o, rx_bit_o}, {2'b11, lfsr[8], lfsr[8] ^ ~i[0]})
        lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[4]};
      end
    end
    bus(IDX_MODEM_CONFIG, 1'b1, 32'h0000_0030);
    @(posedge clock_i);
    tx_bit_i <= 1'b1;
    tx_valid_i <= 1'b1;
    @(posedge clock_i);
    tx_valid_i <= 1'b0;
    #1;
    `CHK({tx_valid_o, tx_bit_o}, 2'b11)
    tally_and_finish();
  end

  // whole sequence needs only a few hundred cycles
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end
endmodule : mfd_top_bench
